// ### sfpa_flash_access.v
`include "sfpa_consts.vh"
module sfpa_flash_access #(
   parameter SIZE_CODE = 2
) (
   // Clock and reset
   input  wire        core_clk,
   input  wire        srst,
   // Register port
   input  wire [7:0]  regAddr,
   input  wire [7:0]  regWrData,
   input  wire        regWrEn,
   input  wire        regRdEn,
   output reg  [7:0]  regRdData,
   // Mode pins
   input  wire        socketModePin,
   input  wire        programVoltageSelect,
   // In-circuit link pins
   input  wire        linkDataIn,
   output wire        linkSerialClock,
   output wire        linkDataOut,
   output wire        linkDataOe,
   // Test-mode RAM loading and execute
   output reg         ramWrEn,
   output reg  [15:0] ramAddr,
   output reg  [7:0]  ramWrData,
   output reg         ictExecute,
   // Status
   output reg         readoutProtected,
   output reg         flashBusy
);
   localparam S_IDLE  = 3'd0;
   localparam S_ERASE = 3'd1;
   localparam S_PROG  = 3'd2;
   localparam S_DONE  = 3'd3;
   localparam S_READ  = 3'd4;

   localparam K_NONE = 3'd0;
   localparam K_PROG = 3'd1;
   localparam K_READ = 3'd2;
   localparam K_SEC  = 3'd3;
   localparam K_BLK  = 3'd4;
   localparam K_OPT  = 3'd5;
   localparam K_RAM  = 3'd6;
   localparam K_EXEC = 3'd7;

   // Sector number of an address, 3 when outside the fitted array
   function [1:0] sectorOf;
      input [15:0] a;
      begin
         if (a[15:12] == 4'hf)
            sectorOf = 2'd0;
         else if (a[15:12] == 4'he && SIZE_CODE >= 1)
            sectorOf = 2'd1;
         else if (a[15:14] == 2'b11 && SIZE_CODE >= 2)
            sectorOf = 2'd2;
         else
            sectorOf = 2'd3;
      end
   endfunction

   // Link command byte to operation kind
   function [2:0] kindOf;
      input [7:0] c;
      begin
         case (c)
            `SFPA_CMD_PROG:   kindOf = K_PROG;
            `SFPA_CMD_READ:   kindOf = K_READ;
            `SFPA_CMD_SECERA: kindOf = K_SEC;
            `SFPA_CMD_BLKERA: kindOf = K_BLK;
            `SFPA_CMD_OPTWR:  kindOf = K_OPT;
            `SFPA_CMD_RAMWR:  kindOf = K_RAM;
            `SFPA_CMD_EXEC:   kindOf = K_EXEC;
            default:          kindOf = K_NONE;
         endcase
      end
   endfunction

   reg  [7:0]  flashMem [0:16383];
   reg  [2:0]  state_reg;
   reg  [7:0]  ctrl_reg;
   reg  [15:0] addr_reg;
   reg  [7:0]  wdata_reg;
   reg  [7:0]  rdata_reg;
   reg  [7:0]  option_reg;
   reg         done_reg;
   reg         refused_reg;
   reg  [1:0]  guard_reg;
   reg         linkPend_reg;
   reg  [31:0] linkFrame_reg;
   reg  [2:0]  opKind_reg;
   reg  [15:0] opAddr_reg;
   reg  [7:0]  opData_reg;
   reg         opLink_reg;
   reg         optAfter_reg;
   reg  [13:0] eraIdx_reg;
   reg  [13:0] eraEnd_reg;
   reg  [3:0]  progCnt_reg;
   reg         ack_reg;
   reg  [7:0]  ackData_reg;
   reg  [2:0]  candKind;
   reg  [15:0] candAddr;
   reg  [7:0]  candData;
   reg         candLink;
   reg         allowed;
   reg  [13:0] blkStart;
   wire [1:0]  modeSync;
   wire        toolMode;
   wire        linkActive;
   wire        frameValid;
   wire [31:0] frameWord;
   wire        regStart;
   wire        protect;

   sfpa_sync #(.WIDTH(2)) uModeSync (
      .core_clk (core_clk),
      .asyncIn  ({programVoltageSelect, socketModePin}),
      .syncOut  (modeSync)
   );

   // The tool switches the link on before any session starts
   assign linkActive = modeSync[1];
   assign toolMode   = modeSync[0] | linkActive;
   assign protect    = option_reg[`SFPA_OPT_PROTECT];
   assign regStart   = regWrEn && regAddr == `SFPA_CTRL_ADDR && guard_reg == 2'd2 &&
                       state_reg == S_IDLE && |regWrData[4:0];

   // Link reaches the pins over clock, data in, data out and data output enable
   sfpa_link uLink (
      .core_clk        (core_clk),
      .srst            (srst),
      .linkEnable      (linkActive),
      .linkDataIn      (linkDataIn),
      .linkSerialClock (linkSerialClock),
      .linkDataOut     (linkDataOut),
      .linkDataOe      (linkDataOe),
      .frameValid      (frameValid),
      .frameWord       (frameWord),
      .ackValid        (ack_reg),
      .ackData         (ackData_reg)
   );

   always @*
   begin
      blkStart = (SIZE_CODE == 0) ? `SFPA_S0_START :
                 (SIZE_CODE == 1) ? `SFPA_S1_START : `SFPA_S2_START;
      if (linkPend_reg)
      begin
         candKind = kindOf(linkFrame_reg[31:24]);
         candAddr = linkFrame_reg[23:8];
         candData = linkFrame_reg[7:0];
         candLink = 1'b1;
      end
      else
      begin
         candKind = ctrl_reg[`SFPA_CTRL_PROG]   ? K_PROG :
                    ctrl_reg[`SFPA_CTRL_SECERA] ? K_SEC  :
                    ctrl_reg[`SFPA_CTRL_BLKERA] ? K_BLK  :
                    ctrl_reg[`SFPA_CTRL_OPTWR]  ? K_OPT  :
                    ctrl_reg[`SFPA_CTRL_READ]   ? K_READ : K_NONE;
         candAddr = addr_reg;
         candData = wdata_reg;
         candLink = 1'b0;
      end
      case (candKind)
         K_PROG, K_SEC:
            // Vector sector locked unless a tool drives the part
            allowed = !protect && sectorOf(candAddr) != 2'd3 &&
                      (toolMode || sectorOf(candAddr) != 2'd0);
         K_BLK:
            allowed = !protect && toolMode;
         K_OPT:
            allowed = toolMode;
         K_READ:
            allowed = sectorOf(candAddr) != 2'd3;
         K_RAM, K_EXEC:
            allowed = candLink;
         default:
            allowed = 1'b0;
      endcase
   end

   always @(posedge core_clk)
   begin
      ack_reg    <= 1'b0;
      ramWrEn    <= 1'b0;
      ictExecute <= 1'b0;
      if (srst)
      begin
         state_reg        <= S_IDLE;
         ctrl_reg         <= `SFPA_CTRL_RESET;
         addr_reg         <= 16'h0000;
         wdata_reg        <= 8'h00;
         rdata_reg        <= 8'h00;
         option_reg       <= `SFPA_OPT_RESET;
         done_reg         <= 1'b0;
         refused_reg      <= 1'b0;
         guard_reg        <= 2'd0;
         linkPend_reg     <= 1'b0;
         linkFrame_reg    <= 32'h0;
         opKind_reg       <= K_NONE;
         opAddr_reg       <= 16'h0000;
         opData_reg       <= 8'h00;
         opLink_reg       <= 1'b0;
         optAfter_reg     <= 1'b0;
         eraIdx_reg       <= 14'h0000;
         eraEnd_reg       <= 14'h0000;
         progCnt_reg      <= 4'd0;
         ackData_reg      <= 8'h00;
         ramAddr          <= 16'h0000;
         ramWrData        <= 8'h00;
         regRdData        <= 8'h00;
         readoutProtected <= 1'b0;
         flashBusy        <= 1'b0;
      end
      else
      begin
         readoutProtected <= protect;
         flashBusy        <= state_reg != S_IDLE;
         if (frameValid)
         begin
            linkPend_reg  <= 1'b1;
            linkFrame_reg <= frameWord;
         end
         // Register writes
         if (regWrEn)
         begin
            case (regAddr)
               `SFPA_ADDRLO_ADDR:
                  addr_reg[7:0] <= regWrData;
               `SFPA_ADDRHI_ADDR:
                  addr_reg[15:8] <= regWrData;
               `SFPA_WDATA_ADDR:
                  wdata_reg <= regWrData;
               `SFPA_GUARD_ADDR:
                  // Two keys in a row arm one start; any other value disarms
                  if (guard_reg == 2'd0 && regWrData == `SFPA_KEY1)
                     guard_reg <= 2'd1;
                  else if (guard_reg == 2'd1 && regWrData == `SFPA_KEY2)
                     guard_reg <= 2'd2;
                  else
                     guard_reg <= 2'd0;
               `SFPA_CTRL_ADDR:
               begin
                  guard_reg <= 2'd0;
                  if (regStart)
                     ctrl_reg <= {3'b000, regWrData[4:0]};
               end
               default:
                  ;
            endcase
         end
         if (regWrEn && regAddr == `SFPA_STATUS_ADDR)
         begin
            done_reg    <= done_reg & ~regWrData[`SFPA_ST_DONE];
            refused_reg <= refused_reg & ~regWrData[`SFPA_ST_REFUSED];
         end
         // Register reads, answered one cycle later
         if (regRdEn)
         begin
            case (regAddr)
               `SFPA_CTRL_ADDR:
                  regRdData <= {state_reg != S_IDLE, ctrl_reg[6:0]};
               `SFPA_ADDRLO_ADDR: regRdData <= addr_reg[7:0];
               `SFPA_ADDRHI_ADDR: regRdData <= addr_reg[15:8];
               `SFPA_WDATA_ADDR:  regRdData <= wdata_reg;
               `SFPA_RDATA_ADDR:  regRdData <= rdata_reg;
               `SFPA_STATUS_ADDR:
                  regRdData <= {2'b00, guard_reg == 2'd2, toolMode, protect,
                                refused_reg, done_reg, state_reg != S_IDLE};
               `SFPA_OPTION_ADDR: regRdData <= option_reg;
               default:           regRdData <= 8'h00;
            endcase
         end
         else
            regRdData <= 8'h00;
         // Operation engine
         case (state_reg)
            S_IDLE:
               if (candKind != K_NONE || linkPend_reg)
               begin
                  opKind_reg   <= candKind;
                  opAddr_reg   <= candAddr;
                  opData_reg   <= candData;
                  opLink_reg   <= candLink;
                  optAfter_reg <= 1'b0;
                  progCnt_reg  <= 4'd0;
                  if (candLink)
                     linkPend_reg <= frameValid;
                  if (!allowed)
                  begin
                     // Refused request touches no flash state
                     refused_reg <= 1'b1;
                     state_reg   <= S_DONE;
                  end
                  else
                     case (candKind)
                        K_PROG, K_OPT:
                           if (candKind == K_OPT && protect &&
                               !candData[`SFPA_OPT_PROTECT])
                           begin
                              // Lifting protection wipes the whole array first
                              optAfter_reg <= 1'b1;
                              eraIdx_reg   <= blkStart;
                              eraEnd_reg   <= `SFPA_ARRAY_END;
                              state_reg    <= S_ERASE;
                           end
                           else
                              state_reg <= S_PROG;
                        K_SEC:
                        begin
                           // Only the chosen sector range is walked
                           case (sectorOf(candAddr))
                              2'd0:    eraIdx_reg <= `SFPA_S0_START;
                              2'd1:    eraIdx_reg <= `SFPA_S1_START;
                              default: eraIdx_reg <= `SFPA_S2_START;
                           endcase
                           case (sectorOf(candAddr))
                              2'd0:    eraEnd_reg <= `SFPA_ARRAY_END;
                              2'd1:    eraEnd_reg <= `SFPA_S1_END;
                              default: eraEnd_reg <= `SFPA_S2_END;
                           endcase
                           state_reg <= S_ERASE;
                        end
                        K_BLK:
                        begin
                           eraIdx_reg <= blkStart;
                           eraEnd_reg <= `SFPA_ARRAY_END;
                           state_reg  <= S_ERASE;
                        end
                        K_RAM:
                        begin
                           ramWrEn   <= 1'b1;
                           ramAddr   <= candAddr;
                           ramWrData <= candData;
                           state_reg <= S_DONE;
                        end
                        K_EXEC:
                        begin
                           ictExecute <= 1'b1;
                           ramAddr    <= candAddr;
                           state_reg  <= S_DONE;
                        end
                        default:
                           state_reg <= S_READ;
                     endcase
               end
            S_ERASE:
            begin
               // One byte per cycle keeps the array a plain single-port memory
               flashMem[eraIdx_reg] <= `SFPA_ERASED;
               eraIdx_reg <= eraIdx_reg + 14'd1;
               if (eraIdx_reg == eraEnd_reg)
                  state_reg <= optAfter_reg ? S_PROG : S_DONE;
            end
            S_PROG:
            begin
               progCnt_reg <= progCnt_reg + 4'd1;
               if (progCnt_reg == `SFPA_PROG_CYCLES - 4'd1)
               begin
                  if (opKind_reg == K_OPT)
                     option_reg <= opData_reg;
                  else
                     flashMem[opAddr_reg[13:0]] <= opData_reg;
                  state_reg <= S_DONE;
               end
            end
            S_READ:
            begin
               // Protected contents never leave over an allowed link read; a refused link read replies with the old rdata_reg
               if (opLink_reg && protect)
                  rdata_reg <= 8'h00;
               else
                  rdata_reg <= flashMem[opAddr_reg[13:0]];
               state_reg <= S_DONE;
            end
            S_DONE:
            begin
               done_reg <= 1'b1;
               ctrl_reg <= `SFPA_CTRL_RESET;
               if (opLink_reg)
               begin
                  ack_reg     <= 1'b1;
                  ackData_reg <= (opKind_reg == K_READ) ? rdata_reg :
                                 {4'h0, protect, refused_reg, 2'b01};
               end
               state_reg <= S_IDLE;
            end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end
endmodule

// ### sfpa_consts.vh
`ifndef SFPA_CONSTS_VH
`define SFPA_CONSTS_VH

// Register offsets
`define SFPA_CTRL_ADDR    8'h38
`define SFPA_ADDRLO_ADDR  8'h40
`define SFPA_ADDRHI_ADDR  8'h41
`define SFPA_WDATA_ADDR   8'h42
`define SFPA_RDATA_ADDR   8'h43
`define SFPA_STATUS_ADDR  8'h44
`define SFPA_GUARD_ADDR   8'h45
`define SFPA_OPTION_ADDR  8'h46
// Control register fields
`define SFPA_CTRL_PROG    0
`define SFPA_CTRL_SECERA  1
`define SFPA_CTRL_BLKERA  2
`define SFPA_CTRL_OPTWR   3
`define SFPA_CTRL_READ    4
`define SFPA_CTRL_BUSY    7
`define SFPA_CTRL_RESET   8'h00
// Status register fields
`define SFPA_ST_BUSY      0
`define SFPA_ST_DONE      1
`define SFPA_ST_REFUSED   2
`define SFPA_ST_PROTECT   3
`define SFPA_ST_TOOL      4
`define SFPA_ST_GUARD     5
// Option byte
`define SFPA_OPT_PROTECT  0
`define SFPA_OPT_RESET    8'h00
// Write guard keys
`define SFPA_KEY1         8'h56
`define SFPA_KEY2         8'hae
// Sector index ranges inside the 16K array
`define SFPA_S0_START     14'h3000
`define SFPA_S1_START     14'h2000
`define SFPA_S1_END       14'h2fff
`define SFPA_S2_START     14'h0000
`define SFPA_S2_END       14'h1fff
`define SFPA_ARRAY_END    14'h3fff
`define SFPA_ERASED       8'hff
// Link commands
`define SFPA_CMD_PROG     8'h01
`define SFPA_CMD_READ     8'h02
`define SFPA_CMD_SECERA   8'h03
`define SFPA_CMD_BLKERA   8'h04
`define SFPA_CMD_OPTWR    8'h05
`define SFPA_CMD_RAMWR    8'h06
`define SFPA_CMD_EXEC     8'h07
// Timing counts in core clock cycles
`define SFPA_PROG_CYCLES  4'd4
`define SFPA_LINK_HALF    3'd4
`endif

// ### sfpa_sync.v
module sfpa_sync #(
   parameter WIDTH = 2
) (
   // Clock
   input  wire             core_clk,
   // Asynchronous inputs and synchronised result
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_reg;

   always @(posedge core_clk)
   begin
      meta_reg <= asyncIn;
      syncOut  <= meta_reg;
   end
endmodule

// ### sfpa_link.v
`include "sfpa_consts.vh"
module sfpa_link (
   // Clock and reset
   input  wire        core_clk,
   input  wire        srst,
   // Session control
   input  wire        linkEnable,
   // Pins
   input  wire        linkDataIn,
   output reg         linkSerialClock,
   output reg         linkDataOut,
   output reg         linkDataOe,
   // Frame towards the engine and reply back from it
   output reg         frameValid,
   output reg  [31:0] frameWord,
   input  wire        ackValid,
   input  wire [7:0]  ackData
);
   localparam L_IDLE = 2'd0;
   localparam L_RX   = 2'd1;
   localparam L_WAIT = 2'd2;
   localparam L_TX   = 2'd3;

   reg  [1:0] state_reg;
   reg  [2:0] div_reg;
   reg  [5:0] bitCnt_reg;
   reg  [7:0] txShift_reg;
   wire       dataSync;
   wire       tick;

   sfpa_sync #(.WIDTH(1)) uDataSync (
      .core_clk (core_clk),
      .asyncIn  (linkDataIn),
      .syncOut  (dataSync)
   );

   assign tick = (div_reg == `SFPA_LINK_HALF - 3'd1);

   always @(posedge core_clk)
   begin
      frameValid <= 1'b0;
      if (srst || !linkEnable)
      begin
         state_reg       <= L_IDLE;
         div_reg         <= 3'd0;
         bitCnt_reg      <= 6'd0;
         txShift_reg     <= 8'h00;
         linkSerialClock <= 1'b0;
         linkDataOut     <= 1'b0;
         linkDataOe      <= 1'b0;
         frameWord       <= 32'h0;
      end
      else
      begin
         div_reg <= tick ? 3'd0 : div_reg + 3'd1;
         case (state_reg)
            L_IDLE:
            begin
               bitCnt_reg <= 6'd0;
               div_reg    <= 3'd0;
               state_reg  <= L_RX;
            end
            L_RX:
               if (tick)
               begin
                  // The device makes the clock and samples on its rising edge
                  linkSerialClock <= ~linkSerialClock;
                  if (!linkSerialClock)
                  begin
                     frameWord  <= {frameWord[30:0], dataSync};
                     bitCnt_reg <= bitCnt_reg + 6'd1;
                     if (bitCnt_reg == 6'd31)
                     begin
                        frameValid <= 1'b1;
                        state_reg  <= L_WAIT;
                     end
                  end
               end
            L_WAIT:
            begin
               if (tick)
                  linkSerialClock <= 1'b0;
               if (ackValid)
               begin
                  txShift_reg <= {ackData[6:0], 1'b0};
                  linkDataOut <= ackData[7];
                  linkDataOe  <= 1'b1;
                  bitCnt_reg  <= 6'd0;
                  state_reg   <= L_TX;
               end
            end
            L_TX:
               if (tick)
               begin
                  // Reply bits change on the falling edge, tool samples on rising
                  linkSerialClock <= ~linkSerialClock;
                  if (!linkSerialClock)
                     bitCnt_reg <= bitCnt_reg + 6'd1;
                  else if (bitCnt_reg == 6'd8)
                  begin
                     linkDataOe <= 1'b0;
                     state_reg  <= L_IDLE;
                  end
                  else
                  begin
                     linkDataOut <= txShift_reg[7];
                     txShift_reg <= {txShift_reg[6:0], 1'b0};
                  end
               end
            default:
               state_reg <= L_IDLE;
         endcase
      end
   end
endmodule

// ### sfpa_access_monitor.sv
module sfpa_access_monitor (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       srst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic       regWrEn,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   // Modes, link and status
   input wire logic       socketModePin,
   input wire logic       programVoltageSelect,
   input wire logic       linkSerialClock,
   input wire logic       linkDataOe,
   input wire logic       ramWrEn,
   input wire logic       ictExecute,
   input wire logic       readoutProtected,
   input wire logic       flashBusy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic freshReg;
   // Lost once anything could have started an operation
   always @(posedge core_clk)
      freshReg <= srst | (freshReg & ~regWrEn & ~programVoltageSelect);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   sequence linkOff;
      !programVoltageSelect [*4];
   endsequence
   sequence toolRead;
      (socketModePin | programVoltageSelect) [*5] ##0 (regRdEn && regAddr == 8'h44);
   endsequence
   rd_idle_a: assert property (!regRdEn |=> regRdData == 8'h00)
      else $error("idle read data");
   ctrl_reset_a: assert property (freshReg && regRdEn && regAddr == 8'h38 |=> regRdData == 8'h00)
      else $error("control not zero");
   mode_stat_a: assert property (toolRead |=> regRdData[4])
      else $error("tool mode not seen");
   opt_mirror_a: assert property (regRdEn && regAddr == 8'h46 |=> regRdData[0] == readoutProtected)
      else $error("protect flag differs");
   busy_stat_a: assert property (regRdEn && regAddr == 8'h44 |=> regRdData[0] == flashBusy)
      else $error("busy flag differs");
   clk_idle_a: assert property (linkOff |-> !linkSerialClock && !linkDataOe)
      else $error("link active off session");
   clk_half_a: assert property ($rose(linkSerialClock) |-> linkSerialClock [*4] ##1 !linkSerialClock)
      else $error("link clock half period");
   test_gate_a: assert property (linkOff |-> !ramWrEn && !ictExecute)
      else $error("test pulse off session");
endmodule
bind sfpa_flash_access sfpa_access_monitor sfpa_access_monitor_inst (.core_clk, .srst, .regAddr, .regWrEn,
   .regRdEn, .regRdData, .socketModePin, .programVoltageSelect, .linkSerialClock, .linkDataOe, .ramWrEn,
   .ictExecute, .readoutProtected, .flashBusy);

// ### sfpa_tool_model.sv
module sfpa_tool_model (
   // Clock
   input wire logic  core_clk,
   // Link pins and programming voltage select
   input wire logic  linkSerialClock,
   input wire logic  linkDataOut,
   input wire logic  linkDataOe,
   output wire logic linkDataIn,
   output logic      programVoltageSelect
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toolDrv = 1'b0;
   logic toolOwn = 1'b0;
   logic idleBit = 1'b0;
   initial programVoltageSelect = 1'b0;
   // Released line shows no stale bit
   always @(posedge core_clk)
      idleBit <= ~idleBit;
   assign linkDataIn = linkDataOe ? linkDataOut : (toolOwn ? toolDrv : idleBit);
   task automatic frame(input logic [31:0] w, output logic [7:0] r, output logic ok);
      int i;
      int n;
      int b;
      logic p;
      i = 31;
      n = 0;
      b = 0;
      p = 1'b0;
      @(posedge core_clk);
      toolDrv <= w[31];
      toolOwn <= 1'b1;
      programVoltageSelect <= 1'b1;
      while ((b < 8 || linkDataOe) && n < 4000)
      begin
         @(posedge core_clk);
         n++;
         // Next bit goes out on the falling edge, ahead of sampling
         if (p && !linkSerialClock && i >= 0)
         begin
            i--;
            toolDrv <= w[i & 31];
            toolOwn <= (i >= 0);
         end
         if (!p && linkSerialClock && linkDataOe)
         begin
            r = {r[6:0], linkDataOut};
            b++;
         end
         p = linkSerialClock;
      end
      ok = (b == 8);
      programVoltageSelect <= 1'b0;
   endtask
endmodule

// ### sector_flash_protection_access_test.sv
`include "sfpa_consts.vh"
module sector_flash_protection_access_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        regWrEn = 1'b0;
   logic        regRdEn = 1'b0;
   logic        socketModePin = 1'b1;
   logic        protModel = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWrData = 8'h00;
   logic [31:0] seed = 32'hec960b27;
   logic [7:0]  regRdData, ramWrData, got, ramLast;
   logic [15:0] ramAddr, a0;
   logic        programVoltageSelect, linkDataIn, linkSerialClock, linkDataOut, linkDataOe;
   logic        ramWrEn, ictExecute, readoutProtected, flashBusy, ok;
   logic [15:0] base [3] = '{16'hc000, 16'he000, 16'hf000};
   logic [15:0] used [$];
   int          mismatches = 0;
   int          num_checks = 0;
   int          execSeen = 0;
   int          memModel [16384];
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      if (ramWrEn === 1'b1)
         ramLast <= ramWrData;
      if (ictExecute === 1'b1)
         execSeen <= execSeen + 1;
   end
   sfpa_flash_access #(.SIZE_CODE(2)) sfpa_flash_access_inst (.core_clk, .srst, .regAddr, .regWrData, .regWrEn,
      .regRdEn, .regRdData, .socketModePin, .programVoltageSelect, .linkDataIn, .linkSerialClock, .linkDataOut,
      .linkDataOe, .ramWrEn, .ramAddr, .ramWrData, .ictExecute, .readoutProtected, .flashBusy);
   sfpa_tool_model sfpa_tool_model_inst (.core_clk, .linkSerialClock, .linkDataOut, .linkDataOe, .linkDataIn,
      .programVoltageSelect);
   function automatic logic [31:0] xrand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge core_clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      @(posedge core_clk);
      got = regRdData;
   endtask
   task automatic op(logic [15:0] a, logic [7:0] d, logic [7:0] ctl, logic guard);
      int n;
      n = 0;
      wr(`SFPA_ADDRLO_ADDR, a[7:0]);
      wr(`SFPA_ADDRHI_ADDR, a[15:8]);
      wr(`SFPA_WDATA_ADDR, d);
      if (guard)
      begin
         wr(`SFPA_GUARD_ADDR, `SFPA_KEY1);
         wr(`SFPA_GUARD_ADDR, `SFPA_KEY2);
      end
      wr(`SFPA_CTRL_ADDR, ctl);
      repeat (3) @(posedge core_clk);
      while (flashBusy !== 1'b0 && n < 20000)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n == 20000)
      begin
         mismatches++;
         results();
      end
   endtask
   task automatic byteChk(logic [15:0] a);
      op(a, 8'h00, 8'h10, 1'b1);
      rd(`SFPA_RDATA_ADDR);
      chk("flash byte", got, memModel[a[13:0]][7:0]);
   endtask
   task automatic prog(logic [15:0] a, logic [7:0] d);
      op(a, d, 8'h01, 1'b1);
      if (!protModel && (socketModePin || a < 16'hf000))
         memModel[a[13:0]] = d;
      byteChk(a);
   endtask
   task automatic link(logic [7:0] c, logic [15:0] a, logic [7:0] d, logic [7:0] exp);
      sfpa_tool_model_inst.frame({c, a, d}, got, ok);
      if (ok !== 1'b1)
      begin
         mismatches++;
         results();
      end
      chk("link reply", got, exp);
   endtask
   initial
   begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rd(`SFPA_CTRL_ADDR);
      chk("control reset", got, `SFPA_CTRL_RESET);
      rd(8'h3a);
      chk("unmapped read", got, 8'h00);
      $display("reset test done");
      op(16'hc000, 8'h00, 8'h04, 1'b1);
      memModel = '{default: 255};
      for (int k = 0; k < 6; k++)
      begin
         a0 = base[k % 3] | (16'(xrand()) & 16'h0fff);
         used.push_back(a0);
         prog(a0, 8'(xrand()));
      end
      $display("tool mode test done");
      socketModePin <= 1'b0;
      foreach (base[s])
         prog(base[s] | 16'h0123, 8'h3c);
      op(16'he456, 8'h00, 8'h02, 1'b1);
      for (int i = 'h2000; i < 'h3000; i++)
         memModel[i] = 255;
      foreach (used[i])
         byteChk(used[i]);
      op(16'hc777, 8'h55, 8'h01, 1'b0);
      byteChk(16'hc777);
      $display("application mode test done");
      socketModePin <= 1'b1;
      op(16'hc000, 8'h01, 8'h08, 1'b1);
      protModel = 1'b1;
      chk("protect flag", {7'h0, readoutProtected}, 8'h01);
      prog(used[0], 8'h00);
      link(`SFPA_CMD_READ, used[0], 8'h00, 8'h00);
      op(16'hc000, 8'h00, 8'h08, 1'b1);
      protModel = 1'b0;
      memModel = '{default: 255};
      foreach (used[i])
         byteChk(used[i]);
      $display("protection test done");
      wr(`SFPA_STATUS_ADDR, 8'h06);
      rd(`SFPA_STATUS_ADDR);
      chk("status", got, 8'h10);
      a0 = 16'he000 | (16'(xrand()) & 16'h0fff);
      link(`SFPA_CMD_PROG, a0, 8'ha5, 8'h01);
      memModel[a0[13:0]] = 8'ha5;
      link(`SFPA_CMD_READ, a0, 8'h00, memModel[a0[13:0]][7:0]);
      link(`SFPA_CMD_RAMWR, 16'h0040, 8'h9e, 8'h01);
      chk("ram byte", ramLast, 8'h9e);
      link(`SFPA_CMD_EXEC, 16'h0040, 8'h00, 8'h01);
      chk("exec pulses", 8'(execSeen), 8'h01);
      link(8'h3f, 16'hc000, 8'h00, 8'h05);
      $display("link test done");
      results();
   end
endmodule
